// ---- core/lsc_pin_ctrl.v ----
// Lock flag, skew step, clock select and control port pin logic
//
// Behaviour
// - Enabled lock flag pin with polarity bit 1 drives 0 when locked, 1 when unlocked.
// - Lock flag pin is tristated while its enable bit is 0.
// - Polarity bit chooses the active level of the lock flag pin.
// - Lock state always mirrored to a status bit, pin enabled or not.
// - Each down pulse lowers skew by one oscillator period, about 200 ps.
// - Each up pulse raises skew by one oscillator period, about 200 ps.
// - Skew accumulator wraps at 16 bits and never saturates.
// - Skew pins step skew only when pin control enabled; else latency setting.
// - Both skew pins high disables phase buildout.
// - Up pulse has no effect when high-speed divider equals 4.
// - Manual mode with select pin enabled: pin 0 picks A, 1 picks B.
// - Select pin enable 0: register bit chooses, pin input ignored.
// - Automatic mode with output enabled drives active input on pin.
// - Automatic mode with alarms on both inputs: indication holds last active input.
// - Active output enable 0 tristates the shared select pin output.
// - Active input identity always mirrored to a status bit.
// - One serial clock pin serves both SPI and I2C control modes.
// - SPI mode drives serial data out; I2C mode is bidirectional.
`timescale 1ns/1ps
`include "lsc_pins_regs.vh"
module lsc_pin_ctrl (
  input wire mclk,
  input wire rst,
  // Lock flag
  input wire pll_locked,
  input wire lock_flag_pin_enable,
  input wire lock_flag_polarity,
  output reg lock_loss_out_o,
  output reg lock_loss_out_oe,
  output reg lock_state_status,
  // Skew control
  input wire skew_down_pulse,
  input wire skew_up_pulse,
  input wire skew_pin_control_enable,
  input wire [`LSC_LAT_W-1:0] output_latency_setting,
  input wire [`LSC_HSDIV_W-1:0] high_speed_output_divider,
  output reg [`LSC_SKEW_W-1:0] skew_setting_q,
  output reg skew_step_up_q,
  output reg skew_step_down_q,
  output reg buildout_disable_q,
  // Input clock select and active indication
  input wire auto_select_mode,
  input wire select_pin_enable,
  input wire select_register_bit,
  input wire active_input_pin_enable,
  input wire auto_active_input,
  input wire alarm_input_clock_a,
  input wire alarm_input_clock_b,
  input wire clock_select_or_active_pin_i,
  output reg clock_select_or_active_pin_o,
  output reg clock_select_or_active_pin_oe,
  output reg selected_input_q,
  output reg active_input_status,
  // Control port pins
  input wire control_port_mode_pin,
  input wire serial_clock_pin,
  input wire shared_serial_data_pin_i,
  output reg shared_serial_data_pin_o,
  output reg shared_serial_data_pin_oe,
  input wire port_data_out,
  input wire port_data_drive,
  output reg control_port_mode_q,
  output reg serial_clock_q,
  output reg serial_data_in_q
);
  wire [`LSC_PIN_N-1:0] pins_raw;
  wire [`LSC_PIN_N-1:0] pins_lvl;
  wire [`LSC_PIN_N-1:0] pins_rise;
  wire [`LSC_SKEW_W-1:0] acc_count;
  wire both_high;
  wire up_ok;
  wire step_up;
  wire step_down;
  wire lock_lost;
  wire digital_hold;
  wire [`LSC_SKEW_W-1:0] latency_ext;
  reg lock_level_d;
  reg active_ind_q;
  reg active_ind_d;
  reg sel_d;
  reg [`LSC_SKEW_W-1:0] skew_d;
  reg sda_o_d;
  reg sda_oe_d;

  // Pins from outside are grouped so one synchroniser serves all
  assign pins_raw[`LSC_PIN_DOWN] = skew_down_pulse;
  assign pins_raw[`LSC_PIN_UP] = skew_up_pulse;
  assign pins_raw[`LSC_PIN_SEL] = clock_select_or_active_pin_i;
  assign pins_raw[`LSC_PIN_SCL] = serial_clock_pin;
  assign pins_raw[`LSC_PIN_SDA] = shared_serial_data_pin_i;
  assign pins_raw[`LSC_PIN_MODE] = control_port_mode_pin;

  lsc_sync_edge #(
    .WIDTH(`LSC_PIN_N)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .pin_in(pins_raw),
    .level(pins_lvl),
    .rise(pins_rise)
  );

  assign both_high = pins_lvl[`LSC_PIN_UP] & pins_lvl[`LSC_PIN_DOWN];

  assign up_ok = (high_speed_output_divider != `LSC_HSDIV_NO_INC);

  // Held-high pair is a mode, not a step; simultaneous rise is ignored
  // steps gated by pin control
  function step_ok;
    input enable;
    input rise;
    input parked;
    begin
      step_ok = enable & rise & ~parked;
    end
  endfunction

  assign step_up = up_ok &
    step_ok(skew_pin_control_enable, pins_rise[`LSC_PIN_UP], both_high);
  assign step_down =
    step_ok(skew_pin_control_enable, pins_rise[`LSC_PIN_DOWN], both_high);

  lsc_skew_acc u_acc (
    .mclk(mclk),
    .rst(rst),
    .step_up(step_up),
    .step_down(step_down),
    .count(acc_count)
  );

  // Signed latency; extend so a negative setting stays negative
  assign latency_ext = {{(`LSC_SKEW_W-`LSC_LAT_W){output_latency_setting[`LSC_LAT_W-1]}},
    output_latency_setting};

  always @*
  begin
    if (skew_pin_control_enable)
    begin
      skew_d = acc_count;
    end
    else
    begin
      skew_d = latency_ext;
    end
  end

  // Skew outputs; the setting lags the step pulse by one cycle
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      skew_setting_q <= `LSC_SKEW_RST;
      skew_step_up_q <= 1'b0;
      skew_step_down_q <= 1'b0;
      buildout_disable_q <= 1'b0;
    end
    else
    begin
      skew_setting_q <= skew_d;
      skew_step_up_q <= step_up;
      skew_step_down_q <= step_down;
      buildout_disable_q <= both_high;
    end
  end

  assign lock_lost = ~pll_locked;

  always @*
  begin
    if (lock_flag_polarity)
    begin
      lock_level_d = lock_lost;
    end
    else
    begin
      lock_level_d = ~lock_lost;
    end
  end

  // Lock flag pin and status
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      lock_loss_out_o <= 1'b0;
      lock_loss_out_oe <= 1'b0;
      lock_state_status <= 1'b0;
    end
    else
    begin
      lock_loss_out_o <= lock_level_d;
      lock_loss_out_oe <= lock_flag_pin_enable;
      lock_state_status <= lock_lost;
    end
  end

  // Manual selection source
  always @*
  begin
    if (select_pin_enable)
    begin
      sel_d = pins_lvl[`LSC_PIN_SEL];
    end
    else
    begin
      sel_d = select_register_bit;
    end
  end

  // Both inputs alarmed means the loop is in digital hold
  assign digital_hold = alarm_input_clock_a & alarm_input_clock_b;

  // Active indication
  always @*
  begin
    active_ind_d = active_ind_q;
    if (!auto_select_mode)
    begin
      active_ind_d = sel_d;
    end
    else if (!digital_hold)
    begin
      active_ind_d = auto_active_input;
    end
  end

  // The pin is input in manual mode; is relied on for a clean level
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      active_ind_q <= `LSC_SEL_A;
      selected_input_q <= `LSC_SEL_A;
      active_input_status <= `LSC_SEL_A;
      clock_select_or_active_pin_o <= 1'b0;
      clock_select_or_active_pin_oe <= 1'b0;
    end
    else
    begin
      active_ind_q <= active_ind_d;
      selected_input_q <= auto_select_mode ? active_ind_d : sel_d;
      active_input_status <= active_ind_d;
      clock_select_or_active_pin_o <= active_ind_d;
      clock_select_or_active_pin_oe <= auto_select_mode & active_input_pin_enable;
    end
  end

  // Shared serial data pin drive
  always @*
  begin
    if (pins_lvl[`LSC_PIN_MODE] == `LSC_MODE_SPI)
    begin
      sda_o_d = port_data_out;
      sda_oe_d = port_data_drive;
    end
    else
    begin
      // Open drain: only ever pulls low, never drives high
      sda_o_d = 1'b0;
      sda_oe_d = port_data_drive & ~port_data_out;
    end
  end

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      control_port_mode_q <= `LSC_MODE_I2C;
      serial_clock_q <= 1'b0;
      serial_data_in_q <= 1'b0;
      shared_serial_data_pin_o <= 1'b0;
      shared_serial_data_pin_oe <= 1'b0;
    end
    else
    begin
      control_port_mode_q <= pins_lvl[`LSC_PIN_MODE];
      serial_clock_q <= pins_lvl[`LSC_PIN_SCL];
      serial_data_in_q <= pins_lvl[`LSC_PIN_SDA];
      shared_serial_data_pin_o <= sda_o_d;
      shared_serial_data_pin_oe <= sda_oe_d;
    end
  end
endmodule // lsc_pin_ctrl

// ---- core/lsc_pins_regs.vh ----
// Constants for the lock, skew and clock-select pin logic
`ifndef LSC_PINS_REGS_VH
`define LSC_PINS_REGS_VH

// Skew accumulator and latency widths
`define LSC_SKEW_W 16
`define LSC_LAT_W 8
`define LSC_SKEW_RST 16'h0000
`define LSC_SKEW_ONE 16'h0001

// One skew step is one internal oscillator period
`define LSC_SKEW_STEP_PS 200

// High-speed output divider field
`define LSC_HSDIV_W 4
`define LSC_HSDIV_NO_INC 4'h4

// Input clock identities
`define LSC_SEL_A 1'b0
`define LSC_SEL_B 1'b1

// Control port modes
`define LSC_MODE_I2C 1'b0
`define LSC_MODE_SPI 1'b1

// Synchronised pin group: bit positions
`define LSC_PIN_N 6
`define LSC_PIN_DOWN 0
`define LSC_PIN_UP 1
`define LSC_PIN_SEL 2
`define LSC_PIN_SCL 3
`define LSC_PIN_SDA 4
`define LSC_PIN_MODE 5

`endif

// ---- core/lsc_skew_acc.v ----
// Wrapping skew accumulator, one count per oscillator period
`timescale 1ns/1ps
`include "lsc_pins_regs.vh"
module lsc_skew_acc (
  input wire mclk,
  input wire rst,
  input wire step_up,
  input wire step_down,
  output wire [`LSC_SKEW_W-1:0] count
);
  reg [`LSC_SKEW_W-1:0] count_q;
  reg [`LSC_SKEW_W-1:0] count_d;

  always @*
  begin
    count_d = count_q;
    if (step_up && !step_down)
    begin
      count_d = count_q + `LSC_SKEW_ONE;
    end
    else if (step_down && !step_up)
    begin
      count_d = count_q - `LSC_SKEW_ONE;
    end
  end

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      count_q <= `LSC_SKEW_RST;
    end
    else
    begin
      count_q <= count_d;
    end
  end

  assign count = count_q;
endmodule // lsc_skew_acc

// ---- core/lsc_sync_edge.v ----
// Two-stage pin synchroniser with rising edge detect per bit
`timescale 1ns/1ps
module lsc_sync_edge #(
  parameter WIDTH = 1
) (
  input wire mclk,
  input wire rst,
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] level,
  output wire [WIDTH-1:0] rise
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      reg meta_q;
      reg sync_q;
      reg last_q;
      // First stage feeds only the second
      always @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
          last_q <= 1'b0;
        end
        else
        begin
          meta_q <= pin_in[i];
          sync_q <= meta_q;
          last_q <= sync_q;
        end
      end
      assign level[i] = sync_q;
      assign rise[i] = sync_q & ~last_q;
    end
  endgenerate
endmodule // lsc_sync_edge

// ---- verification/lsc_board.sv ----
// Board logic model driving skew and select pins
`timescale 1ns/1ps
module lsc_board (
  input wire mclk,
  input wire clock_select_or_active_pin_o,
  input wire clock_select_or_active_pin_oe,
  output reg skew_up_pulse = 1'h0,
  output reg skew_down_pulse = 1'h0,
  output wire clock_select_or_active_pin_i
);
  reg sel_q = 1'h0;
  assign clock_select_or_active_pin_i =
    clock_select_or_active_pin_oe ? clock_select_or_active_pin_o : sel_q;
  task drive(input logic [1:0] w);
    @(posedge mclk);
    {skew_up_pulse, skew_down_pulse} <= w;
  endtask
endmodule // lsc_board

// ---- verification/lsc_pin_chk.sv ----
// Port checker for the pin control block
`timescale 1ns/1ps
`include "lsc_pins_regs.vh"
module lsc_pin_chk (
  input wire mclk,
  input wire rst,
  input wire pll_locked,
  input wire lock_flag_pin_enable,
  input wire lock_flag_polarity,
  input wire lock_loss_out_o,
  input wire lock_loss_out_oe,
  input wire lock_state_status,
  input wire skew_pin_control_enable,
  input wire [`LSC_LAT_W-1:0] output_latency_setting,
  input wire [`LSC_HSDIV_W-1:0] high_speed_output_divider,
  input wire [`LSC_SKEW_W-1:0] skew_setting_q,
  input wire skew_step_up_q,
  input wire skew_step_down_q,
  input wire auto_select_mode,
  input wire active_input_pin_enable,
  input wire clock_select_or_active_pin_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // First edge after reset still shows reset values
  AST_LOCK_LVL: assert property (!$past(rst) |->
    lock_loss_out_o == ($past(lock_flag_polarity) ^ $past(pll_locked)))
    else $error("lock level");
  AST_LOCK_OE: assert property (!$past(rst) |->
    lock_loss_out_oe == $past(lock_flag_pin_enable)) else $error("lock oe");
  AST_LOCK_ST: assert property (!$past(rst) |->
    lock_state_status == !$past(pll_locked)) else $error("lock status");
  AST_STEP_UP: assert property (skew_step_up_q && skew_pin_control_enable |=>
    skew_setting_q == $past(skew_setting_q) + `LSC_SKEW_ONE) else $error("up step");
  AST_STEP_DN: assert property (skew_step_down_q && skew_pin_control_enable |=>
    skew_setting_q == $past(skew_setting_q) - `LSC_SKEW_ONE) else $error("down step");
  AST_DIV4: assert property ($past(high_speed_output_divider) == `LSC_HSDIV_NO_INC |->
    !skew_step_up_q) else $error("up at div 4");
  AST_UP_ONE: assert property (skew_step_up_q |=> !skew_step_up_q)
    else $error("up step twice");
  AST_DN_ONE: assert property (skew_step_down_q |=> !skew_step_down_q)
    else $error("down step twice");
  AST_LAT: assert property (!skew_pin_control_enable && !$past(rst) &&
    !$past(skew_pin_control_enable) |-> skew_setting_q ==
    {{8{$past(output_latency_setting[7])}}, $past(output_latency_setting)})
    else $error("latency");
  AST_CSA_OE: assert property (!$past(rst) |-> clock_select_or_active_pin_oe ==
    ($past(auto_select_mode) && $past(active_input_pin_enable))) else $error("sel oe");
endmodule // lsc_pin_chk
bind lsc_pin_ctrl lsc_pin_chk u_chk (
  .mclk(mclk),
  .rst(rst),
  .pll_locked(pll_locked),
  .lock_flag_pin_enable(lock_flag_pin_enable),
  .lock_flag_polarity(lock_flag_polarity),
  .lock_loss_out_o(lock_loss_out_o),
  .lock_loss_out_oe(lock_loss_out_oe),
  .lock_state_status(lock_state_status),
  .skew_pin_control_enable(skew_pin_control_enable),
  .output_latency_setting(output_latency_setting),
  .high_speed_output_divider(high_speed_output_divider),
  .skew_setting_q(skew_setting_q),
  .skew_step_up_q(skew_step_up_q),
  .skew_step_down_q(skew_step_down_q),
  .auto_select_mode(auto_select_mode),
  .active_input_pin_enable(active_input_pin_enable),
  .clock_select_or_active_pin_oe(clock_select_or_active_pin_oe)
);

// ---- verification/test_lsc_pin_ctrl.sv ----
// Self-checking bench for the pin control block
`timescale 1ns/1ps
module test_lsc_pin_ctrl;
  logic mclk = 0, rst = 1, pll_locked = 0, lock_flag_pin_enable = 0;
  logic lock_flag_polarity = 0, skew_pin_control_enable = 0, auto_select_mode = 0;
  logic select_pin_enable = 0, select_register_bit = 0, active_input_pin_enable = 0;
  logic auto_active_input = 0, alarm_input_clock_a = 0, alarm_input_clock_b = 0;
  logic control_port_mode_pin = 0, serial_clock_pin = 0, shared_serial_data_pin_i = 0;
  logic port_data_out = 0, port_data_drive = 0;
  logic [7:0] output_latency_setting = 8'h00;
  logic [3:0] high_speed_output_divider = 4'h0;
  logic [4:0] pv [4] = '{5'h1F, 5'h12, 5'h01, 5'h0B};
  logic [4:0] ev [4] = '{5'h1F, 5'h12, 5'h01, 5'h08};
  wire skew_up_pulse, skew_down_pulse, clock_select_or_active_pin_i;
  wire lock_loss_out_o, lock_loss_out_oe, lock_state_status, skew_step_up_q;
  wire skew_step_down_q, buildout_disable_q, clock_select_or_active_pin_o;
  wire clock_select_or_active_pin_oe, selected_input_q, active_input_status;
  wire shared_serial_data_pin_o, shared_serial_data_pin_oe, control_port_mode_q;
  wire serial_clock_q, serial_data_in_q;
  wire [15:0] skew_setting_q;
  int failures = 0, samples_checked = 0;
  lsc_pin_ctrl u_dut (
    .mclk(mclk),
    .rst(rst),
    .pll_locked(pll_locked),
    .lock_flag_pin_enable(lock_flag_pin_enable),
    .lock_flag_polarity(lock_flag_polarity),
    .lock_loss_out_o(lock_loss_out_o),
    .lock_loss_out_oe(lock_loss_out_oe),
    .lock_state_status(lock_state_status),
    .skew_down_pulse(skew_down_pulse),
    .skew_up_pulse(skew_up_pulse),
    .skew_pin_control_enable(skew_pin_control_enable),
    .output_latency_setting(output_latency_setting),
    .high_speed_output_divider(high_speed_output_divider),
    .skew_setting_q(skew_setting_q),
    .skew_step_up_q(skew_step_up_q),
    .skew_step_down_q(skew_step_down_q),
    .buildout_disable_q(buildout_disable_q),
    .auto_select_mode(auto_select_mode),
    .select_pin_enable(select_pin_enable),
    .select_register_bit(select_register_bit),
    .active_input_pin_enable(active_input_pin_enable),
    .auto_active_input(auto_active_input),
    .alarm_input_clock_a(alarm_input_clock_a),
    .alarm_input_clock_b(alarm_input_clock_b),
    .clock_select_or_active_pin_i(clock_select_or_active_pin_i),
    .clock_select_or_active_pin_o(clock_select_or_active_pin_o),
    .clock_select_or_active_pin_oe(clock_select_or_active_pin_oe),
    .selected_input_q(selected_input_q),
    .active_input_status(active_input_status),
    .control_port_mode_pin(control_port_mode_pin),
    .serial_clock_pin(serial_clock_pin),
    .shared_serial_data_pin_i(shared_serial_data_pin_i),
    .shared_serial_data_pin_o(shared_serial_data_pin_o),
    .shared_serial_data_pin_oe(shared_serial_data_pin_oe),
    .port_data_out(port_data_out),
    .port_data_drive(port_data_drive),
    .control_port_mode_q(control_port_mode_q),
    .serial_clock_q(serial_clock_q),
    .serial_data_in_q(serial_data_in_q)
  );
  lsc_board u_board (
    .mclk(mclk),
    .clock_select_or_active_pin_o(clock_select_or_active_pin_o),
    .clock_select_or_active_pin_oe(clock_select_or_active_pin_oe),
    .skew_up_pulse(skew_up_pulse),
    .skew_down_pulse(skew_down_pulse),
    .clock_select_or_active_pin_i(clock_select_or_active_pin_i)
  );
  initial forever #25 mclk = ~mclk;
  task go(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  // Pin high three cycles, then low long enough to reach the accumulator
  task pulse(input logic [1:0] w);
    u_board.drive(w);
    go(2);
    u_board.drive(2'h0);
    go(6);
  endtask
  task complete_run;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #100us;
    failures++;
    complete_run();
  end
  initial
  begin
    repeat (2) @(posedge mclk);
    rst <= 0;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge mclk);
      {lock_flag_pin_enable, lock_flag_polarity, pll_locked} <= i[2:0];
      go(2);
      chk("lock", i[1] ^ i[0], lock_loss_out_o);
      chk("lock oe", i[2], lock_loss_out_oe);
      chk("lock st", !i[0], lock_state_status);
    end
    $display("test lock done");
    @(posedge mclk);
    skew_pin_control_enable <= 1;
    pulse(2'h2);
    pulse(2'h2);
    chk("skew", 16'h0002, skew_setting_q);
    repeat (3) pulse(2'h1);
    chk("skew", 16'hFFFF, skew_setting_q);
    @(posedge mclk);
    high_speed_output_divider <= 4'h4;
    pulse(2'h2);
    chk("skew", 16'hFFFF, skew_setting_q);
    u_board.drive(2'h3);
    go(4);
    chk("buildout", 1'h1, buildout_disable_q);
    pulse(2'h0);
    chk("skew", 16'hFFFF, skew_setting_q);
    chk("buildout", 1'h0, buildout_disable_q);
    @(posedge mclk);
    skew_pin_control_enable <= 0;
    output_latency_setting <= 8'hF0;
    high_speed_output_divider <= 4'h0;
    pulse(2'h2);
    chk("skew", 16'hFFF0, skew_setting_q);
    @(posedge mclk);
    skew_pin_control_enable <= 1;
    go(2);
    chk("skew", 16'hFFFF, skew_setting_q);
    $display("test skew done");
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk);
      {select_pin_enable, select_register_bit} <= i[1:0];
      u_board.sel_q <= !i[0];
      go(5);
      chk("sel", i[1] ^ i[0], selected_input_q);
      chk("sel oe", 1'h0, clock_select_or_active_pin_oe);
    end
    @(posedge mclk);
    {auto_select_mode, active_input_pin_enable, auto_active_input} <= 3'h7;
    go(2);
    chk("act", 2'h3, {clock_select_or_active_pin_oe, clock_select_or_active_pin_o});
    @(posedge mclk);
    {alarm_input_clock_a, alarm_input_clock_b} <= 2'h3;
    @(posedge mclk);
    auto_active_input <= 0;
    go(3);
    chk("held", 1'h1, active_input_status);
    @(posedge mclk);
    {alarm_input_clock_a, alarm_input_clock_b, active_input_pin_enable} <= 3'h0;
    go(3);
    chk("act", 2'h0, {clock_select_or_active_pin_oe, active_input_status});
    $display("test select done");
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk);
      {control_port_mode_pin, serial_clock_pin, shared_serial_data_pin_i, port_data_out,
        port_data_drive} <= pv[i];
      go(4);
      chk("port", ev[i], {control_port_mode_q, serial_clock_q, serial_data_in_q,
        shared_serial_data_pin_o, shared_serial_data_pin_oe});
    end
    $display("test port done");
    complete_run();
  end
endmodule // test_lsc_pin_ctrl
